// *** bench/nvac_core_model.sv ***
// core model: processor side io register writes that obey the stall, and reads that do not wait on it
`timescale 1ns/1ps
module nvac_core_model
	import nvac_pkg::*;
(
	input wire logic mclk,
	input wire logic cpuStall,
	input wire logic [7:0] ioRdData,
	output logic ioWr,
	output logic ioRd,
	output logic [5:0] ioAddr,
	output logic [7:0] ioWrData,
	output logic timedOut
);
	initial begin
		ioWr = 1'b0;
		ioRd = 1'b0;
		ioAddr = 6'h00;
		ioWrData = 8'h00;
		timedOut = 1'b0;
	end
	task automatic wr(input logic [5:0] a, input logic [7:0] d, output int n);
		@(negedge mclk);
		ioAddr = a;
		ioWrData = d;
		ioWr = 1'b1;
		@(negedge mclk);
		ioWr = 1'b0;
		ioWrData = ~d; // released bus must not keep looking valid
		n = 0;
		while (cpuStall && n < 9) begin // core halts while stalled
			n++;
			@(negedge mclk);
		end
		if (cpuStall) timedOut = 1'b1;
	endtask
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(negedge mclk);
		ioAddr = a;
		ioRd = 1'b1;
		@(negedge mclk);
		ioRd = 1'b0;
		d = ioRdData;
	endtask
	task automatic waitIdle;
		logic [7:0] c;
		int k;
		k = 0;
		rd(NV_CONTROL_OFS, c);
		while (c[WRITE_STROBE_BIT] !== 1'b0 && k < 200) begin
			k++;
			rd(NV_CONTROL_OFS, c);
		end
		if (c[WRITE_STROBE_BIT] !== 1'b0) timedOut = 1'b1;
	endtask
	task automatic nvWrite(input logic [7:0] a, input logic [7:0] d, output int n);
		waitIdle();
		wr(NV_ADDRESS_OFS, a, n);
		wr(NV_DATA_OFS, d, n);
		wr(NV_CONTROL_OFS, 8'h04, n); // arm with strobe written zero
		wr(NV_CONTROL_OFS, 8'h02, n); // no gap, else the arm expires
	endtask
endmodule

// *** bench/test_nvac_top.sv ***
// testbench: register access, self-timed write, stalls, arming and aborts
`timescale 1ns/1ps
module test_nvac_top;
	import nvac_pkg::*;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] ea;} nvac_row_t;
	logic mclk, arst_n, ioWr, ioRd, cpuStall, writeBusy, timedOut;
	logic [5:0] ioAddr;
	logic [7:0] ioWrData, ioRdData, got;
	int err_count = 0;
	int n_checks = 0;
	int st;
	nvac_row_t rows [4] = '{'{8'h00, 8'h5a, 8'h00}, '{8'h7f, 8'ha5, 8'h7f},
		'{8'hff, 8'h3c, 8'h7f}, '{8'h41, 8'h00, 8'h41}};
	nvac_top #(.WRITE_CYCLES(20)) u_dut (.mclk(mclk), .arst_n(arst_n), .ioWr(ioWr),
		.ioRd(ioRd), .ioAddr(ioAddr), .ioWrData(ioWrData), .ioRdData(ioRdData),
		.cpuStall(cpuStall), .writeBusy(writeBusy));
	nvac_core_model u_core (.mclk(mclk), .cpuStall(cpuStall), .ioRdData(ioRdData),
		.ioWr(ioWr), .ioRd(ioRd), .ioAddr(ioAddr), .ioWrData(ioWrData), .timedOut(timedOut));
	task automatic check(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// data register scrambled first so a stale value cannot pass
	task automatic readLoc(input logic [7:0] a, input logic [7:0] e);
		u_core.waitIdle();
		u_core.wr(NV_ADDRESS_OFS, a, st);
		u_core.wr(NV_DATA_OFS, ~e, st);
		u_core.wr(NV_CONTROL_OFS, 8'h01, st);
		check(8'(st), 8'h04);
		u_core.rd(NV_DATA_OFS, got);
		check(got, e);
		u_core.rd(NV_CONTROL_OFS, got);
		check(got, 8'h00);
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge timedOut) begin
		err_count++;
		report_and_stop();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		arst_n = 1'b0;
		repeat (4) @(posedge mclk);
		@(negedge mclk) arst_n = 1'b1;
		foreach (rows[i]) begin
			u_core.nvWrite(rows[i].a, rows[i].d, st);
			check(8'(st), 8'h02);
			readLoc(rows[i].a, rows[i].d);
			u_core.rd(NV_ADDRESS_OFS, got);
			check(got, rows[i].ea);
		end
		$display("row tests done");
		u_core.wr(NV_CONTROL_OFS, 8'h02, st);
		check(8'(st), 8'h00);
		u_core.rd(NV_CONTROL_OFS, got);
		check(got, 8'h00);
		u_core.wr(NV_CONTROL_OFS, 8'h04, st);
		u_core.rd(NV_CONTROL_OFS, got);
		check(got, 8'h04);
		repeat (4) @(negedge mclk);
		u_core.rd(NV_CONTROL_OFS, got);
		check(got, 8'h00);
		u_core.wr(NV_CONTROL_OFS, 8'h02, st);
		check(8'(st), 8'h00);
		u_core.wr(NV_CONTROL_OFS, 8'h06, st);
		check(8'(st), 8'h00);
		u_core.wr(NV_CONTROL_OFS, 8'h02, st);
		check(8'(st), 8'h00);
		readLoc(8'h00, 8'h5a);
		$display("arming tests done");
		u_core.nvWrite(8'h00, 8'h77, st);
		check(8'(st), 8'h02);
		u_core.rd(NV_CONTROL_OFS, got);
		check(got, 8'h02);
		check({7'h00, writeBusy}, 8'h01);
		u_core.wr(NV_DATA_OFS, 8'h99, st);
		readLoc(8'h00, 8'h5a);
		u_core.wr(NV_ADDRESS_OFS, 8'h00, st);
		u_core.wr(NV_CONTROL_OFS, 8'h04, st);
		u_core.wr(NV_CONTROL_OFS, 8'h02, st);
		check(8'(st), 8'h02);
		$display("stall and abort tests done");
		@(negedge mclk) arst_n = 1'b0;
		@(negedge mclk) arst_n = 1'b1;
		check({7'h00, writeBusy}, 8'h00);
		u_core.rd(NV_ADDRESS_OFS, got);
		check(got, NV_ADDRESS_RST);
		u_core.rd(NV_DATA_OFS, got);
		check(got, NV_DATA_RST);
		u_core.rd(NV_CONTROL_OFS, got);
		check(got, NV_CONTROL_RST);
		$display("reset tests done");
		report_and_stop();
	end
endmodule

// *** src/nvac_array.sv ***
// memory: 128 by 8 data array with registered read port
`timescale 1ns/1ps
module nvac_array
	import nvac_pkg::*;
(
	input wire logic mclk,
	input wire logic wrEn,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [7:0] wrData,
	output logic [7:0] rdData
);
	logic [7:0] mem [ARRAY_DEPTH];

	always_ff @(posedge mclk) begin
		if (wrEn) begin
			mem[addr] <= wrData;
		end
		rdData <= mem[addr];
	end
endmodule

// *** src/nvac_pkg.sv ***
// package: register map and timing constants for the byte eeprom access block
package nvac_pkg;
	localparam logic [5:0] NV_ADDRESS_OFS = 6'h1e;
	localparam logic [5:0] NV_DATA_OFS = 6'h1d;
	localparam logic [5:0] NV_CONTROL_OFS = 6'h1c;
	localparam logic [7:0] NV_ADDRESS_RST = 8'h00;
	localparam logic [7:0] NV_DATA_RST = 8'h00;
	localparam logic [7:0] NV_CONTROL_RST = 8'h00;
	localparam int READ_STROBE_BIT = 0;
	localparam int WRITE_STROBE_BIT = 1;
	localparam int MASTER_ARM_BIT = 2;
	localparam int ARRAY_DEPTH = 128;
	localparam int ADDR_W = 7;
	localparam int ARM_CYCLES = 4;
	localparam int WRITE_STALL_CYCLES = 2;
	localparam int READ_STALL_CYCLES = 4;
	localparam int CLK_PERIOD_NS = 10;
	localparam int WRITE_TIME_US = 2500;
	localparam int WRITE_TIME_CYCLES = WRITE_TIME_US * 1000 / CLK_PERIOD_NS;
endpackage

// *** src/nvac_top.sv ***
// top: eeprom address, data and control registers with self-timed write
// Function
// - address bit 7 always reads zero
// - seven address bits pick one of 128 bytes
// - write stores data register at address
// - read loads data register from address
// - control bits 7..3 always read zero
// - write strobe starts write only when armed
// - master arm clears four cycles after set
// - arm accepted only with strobe written zero
// - write strobe clears when write finishes
// - write strobe stalls core two cycles
// - read strobe self-clears, data then valid
// - read strobe stalls core four cycles
// - read completes within one instruction
// - address/data write during write aborts it, except in the write's final cycle
`timescale 1ns/1ps
module nvac_top
	import nvac_pkg::*;
#(
	parameter int WRITE_CYCLES = WRITE_TIME_CYCLES
)(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic ioWr,
	input wire logic ioRd,
	input wire logic [5:0] ioAddr,
	input wire logic [7:0] ioWrData,
	output logic [7:0] ioRdData,
	output logic cpuStall,
	output logic writeBusy
);
	// ------------------------------------------------------------
	// state machine and registers
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_READ = 3'b010,
		ST_WRITE = 3'b100
	} nvac_state_t;

	nvac_state_t state_reg;
	logic [ADDR_W-1:0] nvAddress_reg;
	logic [7:0] nvData_reg;
	logic masterWriteArm_reg;
	logic writeStrobe_reg;
	logic readStrobe_reg;
	logic [1:0] armCnt_reg;
	logic [2:0] stallCnt_reg;
	logic [31:0] progCnt_reg;
	logic aborted_reg;
	logic [7:0] rdData;
	logic arrayWrEn;

	logic wrAddr;
	logic wrData;
	logic wrCtrl;
	logic startWrite;
	logic startRead;
	logic progDone;

	assign wrAddr = ioWr && ioAddr == NV_ADDRESS_OFS;
	assign wrData = ioWr && ioAddr == NV_DATA_OFS;
	assign wrCtrl = ioWr && ioAddr == NV_CONTROL_OFS;
	// strobe only counts while idle and armed; unarmed strobe is ignored
	assign startWrite = wrCtrl && ioWrData[WRITE_STROBE_BIT] && masterWriteArm_reg
		&& state_reg == ST_IDLE;
	assign startRead = wrCtrl && ioWrData[READ_STROBE_BIT] && !ioWrData[WRITE_STROBE_BIT]
		&& state_reg == ST_IDLE;
	assign progDone = progCnt_reg == 32'(WRITE_CYCLES - 1);
	assign arrayWrEn = state_reg == ST_WRITE && progDone && !aborted_reg;

	nvac_array uArray (
		.mclk(mclk),
		.wrEn(arrayWrEn),
		.addr(nvAddress_reg),
		.wrData(nvData_reg),
		.rdData(rdData)
	);

	// ------------------------------------------------------------
	// address and data registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			nvAddress_reg <= NV_ADDRESS_RST[ADDR_W-1:0];
		end else if (wrAddr) begin
			nvAddress_reg <= ioWrData[ADDR_W-1:0];
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			nvData_reg <= NV_DATA_RST;
		end else if (state_reg == ST_READ && stallCnt_reg == 3'(READ_STALL_CYCLES - 1)) begin
			nvData_reg <= rdData;
		end else if (wrData) begin
			nvData_reg <= ioWrData;
		end
	end

	// ------------------------------------------------------------
	// master arm with timeout
	// ------------------------------------------------------------
	// a fresh arm restarts the window; strobe set in the same write never arms
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			masterWriteArm_reg <= NV_CONTROL_RST[MASTER_ARM_BIT];
			armCnt_reg <= 2'h0;
		end else if (wrCtrl && ioWrData[MASTER_ARM_BIT] && !ioWrData[WRITE_STROBE_BIT]) begin
			masterWriteArm_reg <= 1'b1;
			armCnt_reg <= 2'h0;
		end else if (masterWriteArm_reg) begin
			armCnt_reg <= armCnt_reg + 2'h1;
			if (armCnt_reg == 2'(ARM_CYCLES - 1)) begin
				masterWriteArm_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// access sequencing
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_IDLE;
			writeStrobe_reg <= NV_CONTROL_RST[WRITE_STROBE_BIT];
			readStrobe_reg <= NV_CONTROL_RST[READ_STROBE_BIT];
			progCnt_reg <= 32'h0;
			aborted_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					progCnt_reg <= 32'h0;
					aborted_reg <= 1'b0;
					if (startWrite) begin
						state_reg <= ST_WRITE;
						writeStrobe_reg <= 1'b1;
					end else if (startRead) begin
						state_reg <= ST_READ;
						readStrobe_reg <= 1'b1;
					end
				end
				ST_READ: begin
					if (stallCnt_reg == 3'(READ_STALL_CYCLES - 1)) begin
						state_reg <= ST_IDLE;
						readStrobe_reg <= 1'b0;
					end
				end
				ST_WRITE: begin
					progCnt_reg <= progCnt_reg + 32'h1;
					// result undefined on abort: we simply skip the store
					if (wrAddr || wrData) begin
						aborted_reg <= 1'b1;
					end
					if (progDone) begin
						state_reg <= ST_IDLE;
						writeStrobe_reg <= 1'b0;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// core stall
	// ------------------------------------------------------------
	// stall starts the cycle after the strobe write, before the core's next access
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			stallCnt_reg <= 3'h0;
			cpuStall <= 1'b0;
		end else if (startWrite) begin
			stallCnt_reg <= 3'h0;
			cpuStall <= 1'b1;
		end else if (startRead) begin
			stallCnt_reg <= 3'h0;
			cpuStall <= 1'b1;
		end else if (cpuStall) begin
			stallCnt_reg <= stallCnt_reg + 3'h1;
			if (state_reg == ST_READ) begin
				cpuStall <= stallCnt_reg != 3'(READ_STALL_CYCLES - 1);
			end else begin
				cpuStall <= stallCnt_reg != 3'(WRITE_STALL_CYCLES - 1);
			end
		end else if (state_reg == ST_READ) begin
			stallCnt_reg <= stallCnt_reg + 3'h1;
		end
	end

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	// reserved bits come from constants, so no write can leave them set
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ioRdData <= 8'h00;
			writeBusy <= 1'b0;
		end else begin
			writeBusy <= writeStrobe_reg;
			if (!ioRd) begin
				ioRdData <= 8'h00;
			end else if (ioAddr == NV_ADDRESS_OFS) begin
				ioRdData <= {1'b0, nvAddress_reg};
			end else if (ioAddr == NV_DATA_OFS) begin
				ioRdData <= nvData_reg;
			end else if (ioAddr == NV_CONTROL_OFS) begin
				ioRdData <= {5'h00, masterWriteArm_reg, writeStrobe_reg, readStrobe_reg};
			end else begin
				ioRdData <= 8'h00;
			end
		end
	end

	// ------------------------------------------------------------
	// check helpers
	// ------------------------------------------------------------
	// strobe-high length counted apart from the programming counter
	logic [31:0] busyLen_reg;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			busyLen_reg <= 32'h0;
		end else if (writeStrobe_reg) begin
			busyLen_reg <= busyLen_reg + 32'h1;
		end else begin
			busyLen_reg <= 32'h0;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_arm_timeout: assert property (@(posedge mclk) disable iff (!arst_n)
		$rose(masterWriteArm_reg) ##0 (!wrCtrl) [*4] |=> !masterWriteArm_reg)
		else $error("master arm did not expire");
	chk_unarmed_strobe: assert property (@(posedge mclk) disable iff (!arst_n)
		wrCtrl && ioWrData[WRITE_STROBE_BIT] && !masterWriteArm_reg && state_reg == ST_IDLE
		|=> !writeStrobe_reg)
		else $error("write started without arm");
	chk_write_stall: assert property (@(posedge mclk) disable iff (!arst_n)
		startWrite |=> cpuStall [*2] ##1 !cpuStall)
		else $error("write stall not two cycles");
	chk_read_stall: assert property (@(posedge mclk) disable iff (!arst_n)
		startRead |=> cpuStall [*4] ##1 !cpuStall)
		else $error("read stall not four cycles");
	chk_read_clear: assert property (@(posedge mclk) disable iff (!arst_n)
		startRead |=> readStrobe_reg [*4] ##1 !readStrobe_reg)
		else $error("read strobe did not self clear");
	chk_read_data: assert property (@(posedge mclk) disable iff (!arst_n)
		$fell(readStrobe_reg) |-> nvData_reg == $past(rdData))
		else $error("read data not loaded");
	chk_busy_hold: assert property (@(posedge mclk) disable iff (!arst_n)
		state_reg == ST_WRITE && !progDone |=> writeStrobe_reg)
		else $error("write strobe dropped early");
	chk_write_done: assert property (@(posedge mclk) disable iff (!arst_n)
		state_reg == ST_WRITE && progDone |=> !writeStrobe_reg && state_reg == ST_IDLE)
		else $error("write strobe not cleared at end");
	chk_abort_skip: assert property (@(posedge mclk) disable iff (!arst_n)
		aborted_reg |-> !arrayWrEn)
		else $error("aborted write reached array");
	chk_ctrl_reserved: assert property (@(posedge mclk) disable iff (!arst_n)
		$past(ioRd) && $past(ioAddr) == NV_CONTROL_OFS |-> ioRdData[7:3] == 5'h00)
		else $error("reserved control bits nonzero");
	chk_addr_reserved: assert property (@(posedge mclk) disable iff (!arst_n)
		$past(ioRd) && $past(ioAddr) == NV_ADDRESS_OFS |-> !ioRdData[7])
		else $error("reserved address bit nonzero");
	chk_addr_capture: assert property (@(posedge mclk) disable iff (!arst_n)
		wrAddr |=> nvAddress_reg == $past(ioWrData[ADDR_W-1:0]))
		else $error("address register not loaded");
	chk_data_capture: assert property (@(posedge mclk) disable iff (!arst_n)
		wrData && state_reg == ST_IDLE |=> nvData_reg == $past(ioWrData))
		else $error("data register not loaded");
	chk_write_start: assert property (@(posedge mclk) disable iff (!arst_n)
		startWrite |=> writeStrobe_reg && state_reg == ST_WRITE)
		else $error("armed strobe did not start write");
	chk_arm_accept: assert property (@(posedge mclk) disable iff (!arst_n)
		wrCtrl && ioWrData[MASTER_ARM_BIT] && !ioWrData[WRITE_STROBE_BIT] |=> masterWriteArm_reg)
		else $error("arm write not accepted");
	chk_arm_refuse: assert property (@(posedge mclk) disable iff (!arst_n)
		wrCtrl && ioWrData[WRITE_STROBE_BIT] && !masterWriteArm_reg |=> !masterWriteArm_reg)
		else $error("arm taken with strobe set");
	chk_abort_mark: assert property (@(posedge mclk) disable iff (!arst_n)
		state_reg == ST_WRITE && !progDone && (wrAddr || wrData) |=> aborted_reg)
		else $error("conflicting write did not abort");
	chk_busy_len: assert property (@(posedge mclk) disable iff (!arst_n)
		$fell(writeStrobe_reg) |-> busyLen_reg == 32'(WRITE_CYCLES))
		else $error("write strobe length wrong");

	// ------------------------------------------------------------
	// cover points
	// ------------------------------------------------------------
	cov_write: cover property (@(posedge mclk) disable iff (!arst_n) $fell(writeStrobe_reg));
	cov_read: cover property (@(posedge mclk) disable iff (!arst_n) $fell(readStrobe_reg));
	cov_abort: cover property (@(posedge mclk) disable iff (!arst_n) $rose(aborted_reg));
	cov_expire: cover property (@(posedge mclk) disable iff (!arst_n)
		$fell(masterWriteArm_reg) && state_reg == ST_IDLE);
	cov_late_strobe: cover property (@(posedge mclk) disable iff (!arst_n)
		wrCtrl && ioWrData[WRITE_STROBE_BIT] && !masterWriteArm_reg && state_reg == ST_IDLE);
endmodule
